// ---- src/timer_counter_control_regs.sv ----
// Purpose: 16-bit modulo timer with two channels behind an AHB-Lite slave.
// Assumes: Single word transfers; one wait state per access.
// Notes: Registers sit in bits 7:0 of each word, upper bits read zero.
//
// How it works
// - Overflow flag set at modulo; reset clears.
// - Flag clears by status read, then zero write.
// - Overflow between steps voids the zero write.
// - Writing one to overflow flag changes nothing.
// - Overflow interrupt only when enable bit set.
// - Halt bit holds counter; set at reset.
// - Halt suppresses input captures.
// - Clear bit zeroes counter, prescaler; reads zero.
// - Halt plus clear leaves counter at zero.
// - Divider select picks bus division or pin.
// - Selected clock pin forced to input.
// - High byte read latches low byte.
// - Counter bytes read-only, cleared by reset/clear.
// - After modulo, counting restarts from zero.
// - Modulo high write holds off overflow flag.
// - Reset sets both modulo bytes.
// - Channel flag on capture edge or compare.
// - Channel flag cleared by read, zero write.
// - Writing one to channel flag does nothing.
// - Channels capture or compare, buffered pairing.
// - Channel enable gates channel interrupt.
`timescale 1ns/1ps
module timer_counter_control_regs
  import timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_clock_pin,
  input wire logic port_direction_bit,
  output logic ext_pin_direction,
  input wire logic [1:0] channel_pin_in,
  output logic [1:0] channel_pin_out,
  output logic [1:0] channel_pin_oe_n,
  output logic overflow_irq,
  output logic [1:0] channel_irq
);

  // Whole state of this module
  typedef struct packed {
    bus_phase_type phase; // Bus access phase
    logic hreadyout; // Ready to the bus
    logic [31:0] hrdata; // Read data
    logic pwrite; // Pending access is a write
    reg_sel_type psel; // Pending register
    logic [15:0] cnt; // Counter
    logic [15:0] mod; // Modulo limit
    logic overflow_flag; // Sticky overflow
    logic overflow_irq_enable; // Overflow interrupt gate
    logic counter_halt; // Counter stopped
    logic [2:0] clock_divider_select; // Clock source code
    logic tof_arm; // Status read seen with flag set
    logic mod_wait; // Modulo high written, low awaited
    logic [7:0] low_latch; // Held low counter byte
    logic latch_full; // low_latch in use
    logic restart; // Prescaler clear strobe
    logic [1:0] channel_event_flag; // Channel flags
    logic [1:0] channel_irq_enable; // Channel interrupt gates
    logic [1:0] ch_arm; // Channel clearing sequence armed
    logic [1:0] ch_msa; // Mode select A
    logic msb0; // Buffered pairing on channel 0
    logic [1:0][1:0] ch_els; // Edge/level selects
    logic [1:0] ch_tov; // Toggle on overflow
    logic [1:0] ch_max; // Full duty cycle
    logic [1:0][15:0] ch_val; // Channel values
    logic act_sel; // Buffered pair: active value register
    logic pend_sel; // Buffered pair: last written register
    logic [1:0] pin_s1; // Pin sync first stage
    logic [1:0] pin_s2; // Pin sync second stage
    logic [1:0] pin_prev; // Synced pin last cycle
    logic [1:0] level; // Channel output level
    logic [1:0] oe_n; // Channel pin enable, low drives
    logic ext_dir; // Effective direction of clock pin
    logic ovf_irq; // Overflow request
    logic [1:0] ch_irq; // Channel requests
  } timer_state_type;

  timer_state_type q, d;
  tick_if link ();

  logic take; // Address phase accepted
  logic rd, wr; // Data phase strobes
  logic [7:0] wbyte; // Write data byte
  logic [7:0] rbyte; // Read data byte
  logic step; // Counter advances this cycle
  logic [15:0] cnt_next; // Counter after a step
  logic ovf; // Overflow event
  logic [1:0] hit; // Capture or compare event
  logic [1:0] rise, fall; // Synced pin edges
  logic [15:0] cmp_val; // Compare value in use
  chan_mode_type mode [2]; // Channel modes
  logic [1:0] wr_sc, rd_sc, wr_vh, wr_vl; // Channel register strobes

  // Address decode, shared by the read and write paths
  function automatic reg_sel_type reg_decode(input logic [31:0] a);
    if (a[31:6] != 26'h0)
      return RS_NONE;
    unique case (a[5:0])
      OFS_STATUS: return RS_STATUS;
      OFS_CNT_HIGH: return RS_CNT_HIGH;
      OFS_CNT_LOW: return RS_CNT_LOW;
      OFS_MOD_HIGH: return RS_MOD_HIGH;
      OFS_MOD_LOW: return RS_MOD_LOW;
      OFS_CH0_SC: return RS_CH0_SC;
      OFS_CH1_SC: return RS_CH1_SC;
      OFS_CH0_VAL_HIGH: return RS_CH0_VH;
      OFS_CH0_VAL_LOW: return RS_CH0_VL;
      OFS_CH1_VAL_HIGH: return RS_CH1_VH;
      OFS_CH1_VAL_LOW: return RS_CH1_VL;
      default: return RS_NONE;
    endcase
  endfunction : reg_decode

  // Prescaler and external clock front end
  count_clock_select u_clock (
    .hclk (hclk),
    .hresetn (hresetn),
    .ext_clock_pin (ext_clock_pin),
    .link (link.source)
  );

  assign link.divider_select = q.clock_divider_select;
  assign link.restart = q.restart;

  // Next-state logic: bus, counter, channels
  always_comb
  begin
    d = q;
    take = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    wbyte = hwdata[7:0];
    rbyte = 8'h00;
    d.restart = 1'b0;
    // Bus phases; every access takes one wait state
    unique case (q.phase)
      BUS_IDLE:
      begin
        take = hsel & hready & htrans[1];
        if (take)
        begin
          d.phase = BUS_ACCESS;
          d.hreadyout = 1'b0;
          d.pwrite = hwrite;
          d.psel = reg_decode(haddr);
        end
      end
      BUS_ACCESS:
      begin
        d.phase = BUS_IDLE;
        d.hreadyout = 1'b1;
        rd = ~q.pwrite;
        wr = q.pwrite;
      end
    endcase
    for (int c = 0; c < 2; c++)
    begin
      wr_sc[c] = wr && q.psel == (c == 0 ? RS_CH0_SC : RS_CH1_SC);
      rd_sc[c] = rd && q.psel == (c == 0 ? RS_CH0_SC : RS_CH1_SC);
      wr_vh[c] = wr && q.psel == (c == 0 ? RS_CH0_VH : RS_CH1_VH);
      wr_vl[c] = wr && q.psel == (c == 0 ? RS_CH0_VL : RS_CH1_VL);
    end
    // Read path; side effects of reads happen here too
    if (rd)
    begin
      unique case (q.psel)
        RS_STATUS:
        begin
          // Clear bit always reads zero
          rbyte = {q.overflow_flag, q.overflow_irq_enable,
                   q.counter_halt, 2'b00, q.clock_divider_select};
          if (q.overflow_flag)
            d.tof_arm = 1'b1;
        end
        RS_CNT_HIGH:
        begin
          rbyte = q.cnt[15:8];
          if (!q.latch_full)
          begin
            d.low_latch = q.cnt[7:0];
            d.latch_full = 1'b1;
          end
        end
        RS_CNT_LOW:
        begin
          rbyte = q.latch_full ? q.low_latch : q.cnt[7:0];
          d.latch_full = 1'b0;
        end
        RS_MOD_HIGH: rbyte = q.mod[15:8];
        RS_MOD_LOW: rbyte = q.mod[7:0];
        RS_CH0_SC, RS_CH1_SC:
        begin
          for (int c = 0; c < 2; c++)
            if (rd_sc[c])
            begin
              rbyte = {q.channel_event_flag[c], q.channel_irq_enable[c],
                       (c == 0) & q.msb0, q.ch_msa[c], q.ch_els[c],
                       q.ch_tov[c], q.ch_max[c]};
              if (q.channel_event_flag[c])
                d.ch_arm[c] = 1'b1;
            end
        end
        RS_CH0_VH: rbyte = q.ch_val[0][15:8];
        RS_CH0_VL: rbyte = q.ch_val[0][7:0];
        RS_CH1_VH: rbyte = q.ch_val[1][15:8];
        RS_CH1_VL: rbyte = q.ch_val[1][7:0];
        default: rbyte = 8'h00;
      endcase
      d.hrdata = {24'h000000, rbyte};
    end
    // Write path; counter bytes are read-only
    if (wr && q.psel == RS_STATUS)
    begin
      // A written one on the flag is ignored; zero clears only when armed
      if (!wbyte[FLAG_BIT] && q.tof_arm)
        d.overflow_flag = 1'b0;
      d.tof_arm = 1'b0;
      d.overflow_irq_enable = wbyte[IE_BIT];
      d.counter_halt = wbyte[HALT_BIT];
      d.clock_divider_select = wbyte[DIV_LSB +: 3];
    end
    if (wr && q.psel == RS_MOD_HIGH)
    begin
      d.mod[15:8] = wbyte;
      d.mod_wait = 1'b1;
    end
    if (wr && q.psel == RS_MOD_LOW)
    begin
      d.mod[7:0] = wbyte;
      d.mod_wait = 1'b0;
    end
    for (int c = 0; c < 2; c++)
    begin
      if (wr_sc[c])
      begin
        if (!wbyte[FLAG_BIT] && q.ch_arm[c])
          d.channel_event_flag[c] = 1'b0;
        d.ch_arm[c] = 1'b0;
        d.channel_irq_enable[c] = wbyte[IE_BIT];
        d.ch_msa[c] = wbyte[MSA_BIT];
        d.ch_els[c] = wbyte[ELSB_BIT:ELSA_BIT];
        d.ch_tov[c] = wbyte[TOV_BIT];
        d.ch_max[c] = wbyte[MAX_BIT];
        if (c == 0)
          d.msb0 = wbyte[MSB_BIT];
      end
      if (wr_vh[c])
        d.ch_val[c][15:8] = wbyte;
      if (wr_vl[c])
      begin
        d.ch_val[c][7:0] = wbyte;
        d.pend_sel = (c == 1);
      end
    end
    // Counter: wraps to zero on the tick after reaching modulo
    step = link.tick & ~q.counter_halt;
    cnt_next = (q.cnt == q.mod) ? COUNT_RESET : q.cnt + 16'h0001;
    ovf = step && cnt_next == q.mod;
    if (step)
      d.cnt = cnt_next;
    if (wr && q.psel == RS_STATUS && wbyte[CLEAR_BIT])
    begin
      // Clear beats a coincident tick; halt written in the same word stays
      d.cnt = COUNT_RESET;
      d.restart = 1'b1;
      ovf = 1'b0;
    end
    // Overflow flag; set wins over the clear above
    if (ovf && !q.mod_wait)
    begin
      d.overflow_flag = 1'b1;
      d.tof_arm = 1'b0;
    end
    if (ovf)
      d.act_sel = q.pend_sel;
    // Channels: synchronise pins, detect edges and compares
    d.pin_s1 = channel_pin_in;
    d.pin_s2 = q.pin_s1;
    d.pin_prev = q.pin_s2;
    rise = q.pin_s2 & ~q.pin_prev;
    fall = ~q.pin_s2 & q.pin_prev;
    for (int c = 0; c < 2; c++)
    begin
      // Buffered pairing turns channel 1 off
      mode[c] = (c == 1 && q.msb0) ? CH_PRESET
              : chan_mode((c == 0) & q.msb0, q.ch_msa[c], q.ch_els[c]);
      cmp_val = (c == 0 && q.msb0) ? q.ch_val[q.act_sel] : q.ch_val[c];
      hit[c] = 1'b0;
      unique case (mode[c])
        CH_CAPTURE:
        begin
          hit[c] = ~q.counter_halt &
                   ((q.ch_els[c][0] & rise[c]) |
                    (q.ch_els[c][1] & fall[c]));
          if (hit[c])
            d.ch_val[c] = q.cnt;
          d.oe_n[c] = 1'b1;
        end
        CH_COMPARE:
        begin
          hit[c] = step && cnt_next == cmp_val;
          d.oe_n[c] = 1'b0;
          if (ovf && q.ch_tov[c])
            // Overflow toggle takes precedence over a compare
            d.level[c] = q.ch_max[c] | ~q.level[c];
          else if (hit[c] && !(q.ch_tov[c] && q.ch_max[c]))
            d.level[c] = (q.ch_els[c] == 2'h1) ? ~q.level[c]
                       : q.ch_els[c][0];
        end
        CH_PRESET:
        begin
          // Pin left to the port; output level preset from mode A
          d.level[c] = ~q.ch_msa[c];
          d.oe_n[c] = 1'b1;
        end
        default:
        begin
          d.oe_n[c] = 1'b1;
        end
      endcase
      if (hit[c])
      begin
        d.channel_event_flag[c] = 1'b1;
        d.ch_arm[c] = 1'b0;
      end
    end
    // Pin direction and requests, all registered
    d.ext_dir = (d.clock_divider_select == DIV_EXTERNAL) ? 1'b0
              : port_direction_bit;
    d.ovf_irq = d.overflow_flag & d.overflow_irq_enable
              & ~d.mod_wait;
    d.ch_irq = d.channel_event_flag & d.channel_irq_enable;
  end

  // State register; modulo resets to all ones, counter starts halted
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.hreadyout <= 1'b1;
      q.phase <= BUS_IDLE;
      q.psel <= RS_NONE;
      q.mod <= MOD_RESET;
      q.cnt <= COUNT_RESET;
      q.counter_halt <= HALT_RESET;
      q.clock_divider_select <= DIV_RESET;
      q.level <= 2'b11;
      q.oe_n <= 2'b11;
    end
    else
      q <= d;
  end

  // Outputs straight from the state register; hresp tied to okay
  assign hreadyout = q.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign ext_pin_direction = q.ext_dir;
  assign channel_pin_out = q.level;
  assign channel_pin_oe_n = q.oe_n;
  assign overflow_irq = q.ovf_irq;
  assign channel_irq = q.ch_irq;

endmodule : timer_counter_control_regs

// ---- shared/timer_pkg.sv ----
// Purpose: Shared constants and types of the 16-bit modulo timer block.
// Assumes: Word-aligned AHB-Lite register map, 8-bit registers in low bits.
// Notes: Offsets are byte addresses of 32-bit words.
package timer_pkg;

  // Register byte offsets
  localparam logic [5:0] OFS_STATUS = 6'h00;
  localparam logic [5:0] OFS_CNT_HIGH = 6'h04;
  localparam logic [5:0] OFS_CNT_LOW = 6'h08;
  localparam logic [5:0] OFS_MOD_HIGH = 6'h0C;
  localparam logic [5:0] OFS_MOD_LOW = 6'h10;
  localparam logic [5:0] OFS_CH0_SC = 6'h14;
  localparam logic [5:0] OFS_CH1_SC = 6'h18;
  localparam logic [5:0] OFS_CH0_VAL_HIGH = 6'h1C;
  localparam logic [5:0] OFS_CH0_VAL_LOW = 6'h20;
  localparam logic [5:0] OFS_CH1_VAL_HIGH = 6'h24;
  localparam logic [5:0] OFS_CH1_VAL_LOW = 6'h28;

  // Bit positions, status/control and channel registers
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned IE_BIT = 6;
  localparam int unsigned HALT_BIT = 5;
  localparam int unsigned CLEAR_BIT = 4;
  localparam int unsigned DIV_LSB = 0;
  localparam int unsigned MSB_BIT = 5;
  localparam int unsigned MSA_BIT = 4;
  localparam int unsigned ELSB_BIT = 3;
  localparam int unsigned ELSA_BIT = 2;
  localparam int unsigned TOV_BIT = 1;
  localparam int unsigned MAX_BIT = 0;

  // Reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] MOD_RESET = 16'hFFFF;
  localparam logic HALT_RESET = 1'b1;
  localparam logic [2:0] DIV_RESET = 3'h0;

  // Clock selection
  localparam logic [2:0] DIV_EXTERNAL = 3'h7;
  localparam int unsigned PRESCALE_BITS = 6;

  // Bus phase
  typedef enum logic {BUS_IDLE = 1'b0, BUS_ACCESS = 1'b1} bus_phase_type;

  // Register selected by an address
  typedef enum logic [3:0] {
    RS_STATUS = 4'h0, RS_CNT_HIGH = 4'h1, RS_CNT_LOW = 4'h2,
    RS_MOD_HIGH = 4'h3, RS_MOD_LOW = 4'h4, RS_CH0_SC = 4'h5,
    RS_CH1_SC = 4'h6, RS_CH0_VH = 4'h7, RS_CH0_VL = 4'h8,
    RS_CH1_VH = 4'h9, RS_CH1_VL = 4'hA, RS_NONE = 4'hF
  } reg_sel_type;

  // Channel operating mode
  typedef enum logic [1:0] {
    CH_PRESET = 2'h0, CH_CAPTURE = 2'h1, CH_COMPARE = 2'h2
  } chan_mode_type;

  // Mode from the buffered, mode-A and edge/level bits
  function automatic chan_mode_type chan_mode(input logic msb,
                                              input logic msa,
                                              input logic [1:0] els);
    if (els == 2'h0)
      return CH_PRESET;
    else if (msb || msa)
      return CH_COMPARE;
    else
      return CH_CAPTURE;
  endfunction : chan_mode

endpackage : timer_pkg

// ---- shared/tick_if.sv ----
// Purpose: Carries the counter clock selection and its tick between modules.
// Assumes: Both ends on hclk.
// Notes: restart zeroes the prescaler for one cycle.
`timescale 1ns/1ps
interface tick_if;
  logic [2:0] divider_select; // Clock divider code
  logic restart; // Prescaler clear
  logic tick; // One-cycle counter tick
  modport source (input divider_select, input restart, output tick);
  modport user (output divider_select, output restart, input tick);
endinterface : tick_if

// ---- src/count_clock_select.sv ----
// Purpose: Prescaler and external count clock edge detector.
// Assumes: External clock well below hclk; it is synchronised here.
// Notes: tick is a registered one-cycle pulse.
`timescale 1ns/1ps
module count_clock_select
  import timer_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ext_clock_pin,
  tick_if.source link
);

  // Whole state of this module
  typedef struct packed {
    logic [PRESCALE_BITS-1:0] presc; // Free-running prescaler
    logic ext_s1; // First sync stage, read only by ext_s2
    logic ext_s2; // Second sync stage
    logic ext_prev; // Previous synced level for edge detect
    logic tick; // Registered tick
  } clk_state_type;

  clk_state_type q, d;
  logic [PRESCALE_BITS-1:0] mask;

  // Prescaler, synchroniser and tick selection
  always_comb
  begin
    d = q;
    mask = PRESCALE_BITS'((7'h01 << link.divider_select) - 7'h01);
    d.ext_s1 = ext_clock_pin;
    d.ext_s2 = q.ext_s1;
    d.ext_prev = q.ext_s2;
    if (link.restart)
    begin
      // Clearing the prescaler drops any pending tick
      d.presc = '0;
      d.tick = 1'b0;
    end
    else
    begin
      d.presc = q.presc + 1'b1;
      if (link.divider_select == DIV_EXTERNAL)
        // Rising edges only; pin rate bounded by the far side
        d.tick = q.ext_s2 & ~q.ext_prev;
      else
        d.tick = (q.presc & mask) == mask;
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= '0;
    else
      q <= d;
  end

  assign link.tick = q.tick;

endmodule : count_clock_select

// ---- testbench/timer_counter_control_regs_assertions.sv ----
// Purpose: Port-level checks on the timer register block.
// Assumes: One AHB-Lite slave, hready looped back from hreadyout.
// Notes: Bound to every instance of the block.
`timescale 1ns/1ps
module timer_counter_control_regs_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic port_direction_bit,
  input wire logic ext_pin_direction,
  input wire logic overflow_irq,
  input wire logic [1:0] channel_irq
);
  logic [3:0] wr_age_q; // Cycles since a write was taken
  logic [3:0] wr_age_d;
  logic rd_wait_q; // A read sits in its wait cycle
  wire logic taken = hsel && hready && htrans[1] && hreadyout;

  // Saturating age, so an old write never excuses a dropped request
  always_comb
  begin
    wr_age_d = (wr_age_q == 4'hF) ? wr_age_q : wr_age_q + 4'h1;
    if (taken && hwrite)
      wr_age_d = 4'h0;
  end

  // Helper state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_age_q <= 4'hF;
      rd_wait_q <= 1'b0;
    end
    else
    begin
      wr_age_q <= wr_age_d;
      rd_wait_q <= taken && !hwrite;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_taken;
    hsel && hready && htrans[1] && hreadyout;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_wait_one: assert property (s_taken |=> s_wait)
    else $error("access did not take exactly one wait cycle");
  a_idle_ready: assert property
    (hreadyout && !(hsel && htrans[1]) |=> hreadyout)
    else $error("ready dropped without a request");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response other than okay");
  a_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_rdata_stands: assert property (!$stable(hrdata) |-> $past(rd_wait_q))
    else $error("read data changed outside a read");
  a_ovf_irq_hold: assert property
    ($fell(overflow_irq) |-> wr_age_q < 4'h6)
    else $error("overflow request dropped without a write");
  a_ch_irq_hold: assert property
    (|($past(channel_irq) & ~channel_irq) |-> wr_age_q < 4'h6)
    else $error("channel request dropped without a write");
  a_pin_input_only: assert property
    (ext_pin_direction |-> $past(port_direction_bit))
    else $error("clock pin turned output against port bit");
endmodule : timer_counter_control_regs_assertions

bind timer_counter_control_regs timer_counter_control_regs_assertions
  chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .port_direction_bit, .ext_pin_direction,
  .overflow_irq, .channel_irq);

// ---- testbench/timer_counter_control_regs_bench.sv ----
// Purpose: Self-checking bench for the timer register block.
// Assumes: Bench is the only bus master; hready looped from hreadyout.
// Notes: Prescaled counts are checked inside a small window.
`timescale 1ns/1ps
module timer_counter_control_regs_bench
  import timer_pkg::*;
;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [2:0] pins; // Channel one, channel zero, clock pin
  logic port_dir; // Port direction bit of the clock pin
  wire logic hreadyout;
  wire logic [31:0] hrdata;
  wire logic ext_pin_direction;
  wire logic overflow_irq;
  wire logic [1:0] channel_irq;
  wire logic [1:0] ch_out; // Channel output levels
  wire logic [1:0] ch_oe_n; // Channel pin enables, low drives
  logic rdy_n; // Values seen mid-cycle, away from the rising edge
  logic dir_n;
  logic [2:0] irq_n;
  logic [3:0] pin_n; // Channel enables over channel levels
  logic [7:0] r;
  int mismatches;
  int compares;

  timer_counter_control_regs dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .ext_clock_pin(pins[0]), .port_direction_bit(port_dir),
    .ext_pin_direction(ext_pin_direction), .channel_pin_in(pins[2:1]),
    .channel_pin_out(ch_out), .channel_pin_oe_n(ch_oe_n),
    .overflow_irq(overflow_irq), .channel_irq(channel_irq));

  // 100 ns bus clock
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Sample on the falling edge so reads never race the design
  always @(negedge hclk)
  begin
    rdy_n = hreadyout;
    dir_n = ext_pin_direction;
    irq_n = {channel_irq, overflow_irq};
    pin_n = {ch_oe_n, ch_out};
  end

  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Wait for an edge at which hready was high, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (!rdy_n && n < 40);
    if (!rdy_n)
    begin
      mismatches++;
      close_out();
    end
  endtask : wait_rdy

  // One single AHB-Lite transfer; read data taken with the last ready
  task automatic bus(input logic [5:0] a, input logic w,
                     input logic [7:0] d, output logic [7:0] q);
    haddr <= {26'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    wait_rdy();
    q = hrdata[7:0];
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rdc(input logic [5:0] a, input logic [7:0] e,
                     input string nm);
    logic [7:0] q;
    bus(a, 1'b0, 8'h00, q);
    chk(nm, e, q);
  endtask : rdc

  // Pin pulses at an eighth of the bus clock, under 4 MHz
  task automatic pulse(input int n, input logic [2:0] m);
    repeat (n)
    begin
      pins <= m;
      tick(4);
      pins <= 3'h0;
      tick(4);
    end
  endtask : pulse

  // Hang guard, far beyond the few thousand cycles of the run
  initial
  begin
    tick(30000);
    mismatches++;
    close_out();
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    pins = 3'h0;
    port_dir = 1'b1;
    mismatches = 0;
    compares = 0;
    tick(16);
    hresetn <= 1'b1;
    tick(1);
    // Reset values and access kinds
    rdc(OFS_STATUS, 8'h20, "status reset");
    rdc(OFS_MOD_HIGH, 8'hFF, "mod high reset");
    rdc(OFS_MOD_LOW, 8'hFF, "mod low reset");
    rdc(OFS_CNT_HIGH, 8'h00, "cnt high reset");
    wr(OFS_CNT_LOW, 8'h55);
    rdc(OFS_CNT_LOW, 8'h00, "cnt read only");
    wr(6'h2C, 8'hA5);
    rdc(6'h2C, 8'h00, "unmapped");
    chk("pin dir port", 8'h01, {7'h0, dir_n});
    // Internal clock: the pin follows its port bit
    port_dir <= 1'b0;
    tick(2);
    chk("pin dir follows", 8'h00, {7'h0, dir_n});
    port_dir <= 1'b1;
    // Every bus-clock division, modulo 255 kept out of reach
    wr(OFS_MOD_HIGH, 8'h00);
    wr(OFS_MOD_LOW, 8'hFF);
    for (int c = 0; c < 7; c++)
    begin
      wr(OFS_STATUS, {5'h06, c[2:0]});
      rdc(OFS_STATUS, {5'h04, c[2:0]}, "clear reads 0");
      rdc(OFS_CNT_LOW, 8'h00, "halt clear");
      wr(OFS_STATUS, {5'h00, c[2:0]});
      tick(32 << c);
      wr(OFS_STATUS, {5'h04, c[2:0]});
      bus(OFS_CNT_HIGH, 1'b0, 8'h00, r);
      bus(OFS_CNT_LOW, 1'b0, 8'h00, r);
      chk("divider", 8'h01, {7'h0, r >= 8'h1F && r <= 8'h26});
    end
    // External clock pin, coherent byte reads
    wr(OFS_STATUS, 8'h37);
    wr(OFS_STATUS, 8'h07);
    tick(2);
    chk("pin dir ext", 8'h00, {7'h0, dir_n});
    pulse(3, 3'h1);
    rdc(OFS_CNT_HIGH, 8'h00, "cnt high");
    pulse(2, 3'h1);
    rdc(OFS_CNT_HIGH, 8'h00, "cnt high again");
    rdc(OFS_CNT_LOW, 8'h03, "latched low");
    wr(OFS_STATUS, 8'h27);
    pulse(2, 3'h1);
    rdc(OFS_CNT_LOW, 8'h05, "halted count");
    // Modulo 5; high write holds the flag off until the low write
    wr(OFS_STATUS, 8'h30);
    wr(OFS_MOD_LOW, 8'h05);
    wr(OFS_MOD_HIGH, 8'h00);
    wr(OFS_STATUS, 8'h40);
    tick(40);
    rdc(OFS_STATUS, 8'h40, "held off");
    chk("irq held off", 8'h00, {7'h0, irq_n[0]});
    wr(OFS_STATUS, 8'h30);
    wr(OFS_MOD_LOW, 8'h05);
    wr(OFS_STATUS, 8'h40);
    tick(20);
    rdc(OFS_STATUS, 8'hC0, "overflow");
    chk("irq on", 8'h01, {7'h0, irq_n[0]});
    // Writing one, unarmed zero, then the proper clear
    wr(OFS_STATUS, 8'hE0);
    wr(OFS_STATUS, 8'h60);
    rdc(OFS_STATUS, 8'hE0, "unarmed clear");
    bus(OFS_CNT_HIGH, 1'b0, 8'h00, r);
    bus(OFS_CNT_LOW, 1'b0, 8'h00, r);
    chk("wraps", 8'h01, {7'h0, r <= 8'h05});
    wr(OFS_STATUS, 8'h60);
    rdc(OFS_STATUS, 8'h60, "cleared");
    tick(2);
    chk("irq off", 8'h00, {7'h0, irq_n[0]});
    // A new overflow between read and zero write wins
    wr(OFS_STATUS, 8'h40);
    tick(20);
    rdc(OFS_STATUS, 8'hC0, "armed");
    tick(8);
    wr(OFS_STATUS, 8'h40);
    rdc(OFS_STATUS, 8'hC0, "late clear");
    // Channel zero capture on rising edge
    wr(OFS_CH0_SC, 8'h04);
    tick(4);
    pulse(1, 3'h2);
    rdc(OFS_CH0_SC, 8'h84, "capture flag");
    chk("ch irq gated", 8'h00, {7'h0, irq_n[1]});
    wr(OFS_CH0_SC, 8'hC4);
    rdc(OFS_CH0_SC, 8'hC4, "ch write one");
    tick(2);
    chk("ch irq on", 8'h01, {7'h0, irq_n[1]});
    wr(OFS_CH0_SC, 8'h44);
    rdc(OFS_CH0_SC, 8'h44, "ch cleared");
    wr(OFS_STATUS, 8'h20);
    pulse(1, 3'h2);
    rdc(OFS_CH0_SC, 8'h44, "halted capture");
    // Reset in mid-run, with the overflow flag and channel enable set
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    tick(1);
    rdc(OFS_STATUS, 8'h20, "status after reset");
    rdc(OFS_CH0_SC, 8'h00, "ch0 after reset");
    // Channel one compare at 3, clearing its output
    wr(OFS_CH1_VAL_HIGH, 8'h00);
    wr(OFS_CH1_VAL_LOW, 8'h03);
    wr(OFS_CH1_SC, 8'h18);
    tick(2);
    chk("ch1 drives", 8'h00, {7'h0, pin_n[3]});
    chk("ch1 level", 8'h01, {7'h0, pin_n[1]});
    wr(OFS_STATUS, 8'h00);
    tick(8);
    chk("compare level", 8'h00, {7'h0, pin_n[1]});
    rdc(OFS_CH1_SC, 8'h98, "compare flag");
    close_out();
  end
endmodule : timer_counter_control_regs_bench
